// >>> inc/fcd_pkg.sv
// Constants, register map and field layout of the frequency and current
// level detector.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
// How it works
// - At-speed flag rises when output frequency is within the band of set frequency.
// - Speed band defaults to 10 percent, range 0 to 100, relative to set frequency.
// - Frequency-level flag rises when output frequency reaches the detect level (6 Hz).
// - Reverse level applies in reverse unless it holds 9999, then forward level applies.
// - During DC injection braking all frequency flags are forced off.
// - Comparisons use output frequency before slip compensation.
// - At-speed flag goes to a terminal with code 1, or inverted with code 101.
// - Frequency-level flag has its own terminal, also codes 4 and 104.
// - Over-current flag rises after current stays above level longer than the delay.
// - Over-current level defaults to 150 percent of rated current, range 0 to 200.
// - Over-current flag holds at least 100 ms once on.
// - Zero-current flag rises after current stays below level longer than the time.
// - Zero-current level of 0 disables zero-current detection.
// - Over-current flag goes to a terminal with code 12, or inverted with 112.
// - Zero-current flag goes to a terminal with code 13, or inverted with 113.
// - Current flags respond within about 0.1 s of the condition.
// - Current detection stays active during offline auto-tuning.
// - Codes 0 to 99 conduct when active; codes 100 to 199 block when active.

package fcd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 17;
  localparam int OC_HOLD_MS = 100;
  localparam logic [13:0] OC_DLY_MS_PER_LSB = 14'h0064;
  localparam logic [13:0] ZC_TIME_MS_PER_LSB = 14'h000A;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int FREQ_W = 12;
  localparam int CUR_W = 11;
  localparam int SEL_W = 8;
  localparam int DLY_W = 14;
  localparam int HOLD_W = 7;
  localparam logic [15:0] BAND_MAX = 16'h0064;
  localparam logic [15:0] FREQ_MAX = 16'h0FA0;
  localparam logic [15:0] CUR_MAX = 16'h07D0;
  localparam logic [15:0] TIME_MAX = 16'h0064;
  localparam logic [15:0] SEL_MAX = 16'h00C7;
  localparam logic [13:0] REV_SENTINEL = 14'h270F;
  localparam logic [19:0] PCT_SCALE = 20'h00064;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [6:0] BAND_RST = 7'h0A;
  localparam logic [FREQ_W-1:0] FREQ_LVL_RST = 12'h03C;
  localparam logic [13:0] REV_LVL_RST = 14'h270F;
  localparam logic [CUR_W-1:0] OC_LVL_RST = 11'h5DC;
  localparam logic [6:0] OC_DLY_RST = 7'h00;
  localparam logic [CUR_W-1:0] ZC_LVL_RST = 11'h032;
  localparam logic [6:0] ZC_TIME_RST = 7'h32;
  localparam logic [SEL_W-1:0] TERM0_RST = 8'h01;
  localparam logic [SEL_W-1:0] TERM1_RST = 8'h0C;
  localparam logic [SEL_W-1:0] TERM2_RST = 8'h0D;

  // ****************************************
  // Terminal selector codes
  // ****************************************
  localparam logic [SEL_W-1:0] SEL_SP = 8'h01;
  localparam logic [SEL_W-1:0] SEL_FQ = 8'h04;
  localparam logic [SEL_W-1:0] SEL_OC = 8'h0C;
  localparam logic [SEL_W-1:0] SEL_ZC = 8'h0D;
  localparam logic [SEL_W-1:0] SEL_NEG_BASE = 8'h64;
  localparam logic [SEL_W-1:0] SEL_NEG_LAST = 8'hC7;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_BAND = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FREQ_LVL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_REV_LVL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OC_LVL = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_OC_DLY = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ZC_LVL = 8'h14;
  localparam logic [ADDR_W-1:0] REG_ZC_TIME = 8'h18;
  localparam logic [ADDR_W-1:0] REG_TERM = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TERM0_LSB = 0;
  localparam int TERM1_LSB = 8;
  localparam int TERM2_LSB = 16;
  localparam int ST_SP = 0;
  localparam int ST_FQ = 1;
  localparam int ST_OC = 2;
  localparam int ST_ZC = 3;
  localparam int ST_TERM_LSB = 4;
  localparam int ST_FQ_TERM = 7;

endpackage

// >>> rtl/fcd_delay_timer.sv
// Qualification timer: flag rises once a condition has held for a limit.
// Assumes a one-cycle millisecond tick from the same clock domain.
`timescale 1ns/100ps

module fcd_delay_timer
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic qualify,
  input wire logic [fcd_pkg::DLY_W-1:0] limit,
  output logic done
);

  logic [fcd_pkg::DLY_W-1:0] cnt_ff;
  logic [fcd_pkg::DLY_W-1:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // ****************************************
  // Counter
  // ****************************************
  // Any lapse drops the count, so only an unbroken condition fires
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (!qualify)
      nxt_cnt = '0;
    else if (tick && (cnt_ff < limit))
      nxt_cnt = cnt_ff + 1'b1;
    nxt_done = qualify && (cnt_ff >= limit);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

// >>> rtl/fcd_term_sel.sv
// Output terminal selector for three assignable terminals and the
// dedicated frequency-level terminal.
// Assumes flags from the same clock domain; unknown codes mean no function.
`timescale 1ns/100ps

module fcd_term_sel
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sp_flag,
  input wire logic fq_flag,
  input wire logic oc_flag,
  input wire logic zc_flag,
  input wire logic [3*fcd_pkg::SEL_W-1:0] sel_codes,
  output logic [2:0] term_out,
  output logic fq_term_out
);

  logic [2:0] term_ff;
  logic [2:0] nxt_term;
  logic fq_term_ff;
  logic nxt_fq_term;

  // Map one selector code onto the terminal drive level
  function automatic logic drive(input logic [fcd_pkg::SEL_W-1:0] code,
                                 input logic [3:0] flags);
    logic neg;
    logic [fcd_pkg::SEL_W-1:0] base;
    logic act;
    neg = (code >= fcd_pkg::SEL_NEG_BASE) && (code <= fcd_pkg::SEL_NEG_LAST);
    base = neg ? code - fcd_pkg::SEL_NEG_BASE : code;
    act = 1'b0;
    if (base == fcd_pkg::SEL_SP)
      act = flags[0];
    else if (base == fcd_pkg::SEL_FQ)
      act = flags[1];
    else if (base == fcd_pkg::SEL_OC)
      act = flags[2];
    else if (base == fcd_pkg::SEL_ZC)
      act = flags[3];
    return act ^ neg;
  endfunction

  // ****************************************
  // Terminal drive
  // ****************************************
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      nxt_term[i] = drive(sel_codes[i*fcd_pkg::SEL_W +: fcd_pkg::SEL_W],
                          {zc_flag, oc_flag, fq_flag, sp_flag});
    nxt_fq_term = fq_flag;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      term_ff <= '0;
      fq_term_ff <= 1'b0;
    end
    else
    begin
      term_ff <= nxt_term;
      fq_term_ff <= nxt_fq_term;
    end
  end

  assign term_out = term_ff;
  assign fq_term_out = fq_term_ff;

endmodule

// >>> rtl/fcd_top.sv
// Frequency and current level detector: configuration registers on APB,
// at-speed and frequency-level compare, over- and zero-current timers.
// Assumes drive-core inputs come from logic on pclk, so none is synchronised.
`timescale 1ns/100ps

module fcd_top
#(
  parameter int TICK_CYCLES = fcd_pkg::TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [fcd_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fcd_pkg::FREQ_W-1:0] out_freq_pre_slip,
  input wire logic [fcd_pkg::FREQ_W-1:0] set_freq,
  input wire logic dir_reverse,
  input wire logic [fcd_pkg::CUR_W-1:0] out_current,
  input wire logic drive_running,
  input wire logic dc_brake_active,
  input wire logic autotune_active,
  output logic at_speed_flag,
  output logic freq_level_flag,
  output logic overcurrent_level_flag,
  output logic zero_current_flag,
  output logic [2:0] term_out,
  output logic fq_term_out
);

  // Saturate a written value to the top of its range
  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] mx);
    return (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [6:0] band_ff;
  logic [6:0] nxt_band;
  logic [fcd_pkg::FREQ_W-1:0] freq_lvl_ff;
  logic [fcd_pkg::FREQ_W-1:0] nxt_freq_lvl;
  logic [13:0] rev_lvl_ff;
  logic [13:0] nxt_rev_lvl;
  logic [fcd_pkg::CUR_W-1:0] oc_lvl_ff;
  logic [fcd_pkg::CUR_W-1:0] nxt_oc_lvl;
  logic [6:0] oc_dly_ff;
  logic [6:0] nxt_oc_dly;
  logic [fcd_pkg::CUR_W-1:0] zc_lvl_ff;
  logic [fcd_pkg::CUR_W-1:0] nxt_zc_lvl;
  logic [6:0] zc_time_ff;
  logic [6:0] nxt_zc_time;
  logic [3*fcd_pkg::SEL_W-1:0] term_sel_ff;
  logic [3*fcd_pkg::SEL_W-1:0] nxt_term_sel;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic wr_en;
  logic mapped;
  logic [15:0] wlim;
  logic [31:0] status_word;
  logic [7:0] sel_w;

  assign wr_en = psel && penable && pwrite;
  assign mapped = (paddr == fcd_pkg::REG_BAND) || (paddr == fcd_pkg::REG_FREQ_LVL)
               || (paddr == fcd_pkg::REG_REV_LVL) || (paddr == fcd_pkg::REG_OC_LVL)
               || (paddr == fcd_pkg::REG_OC_DLY) || (paddr == fcd_pkg::REG_ZC_LVL)
               || (paddr == fcd_pkg::REG_ZC_TIME) || (paddr == fcd_pkg::REG_TERM)
               || (paddr == fcd_pkg::REG_STATUS);

  // Zero wait states; unmapped or status writes answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable
                && (!mapped || (pwrite && (paddr == fcd_pkg::REG_STATUS)));
  assign prdata = prdata_ff;

  // Write decode; out-of-range values are saturated, not rejected
  always_comb
  begin
    nxt_band = band_ff;
    nxt_freq_lvl = freq_lvl_ff;
    nxt_rev_lvl = rev_lvl_ff;
    nxt_oc_lvl = oc_lvl_ff;
    nxt_oc_dly = oc_dly_ff;
    nxt_zc_lvl = zc_lvl_ff;
    nxt_zc_time = zc_time_ff;
    nxt_term_sel = term_sel_ff;
    wlim = 16'h0000;
    sel_w = 8'h00;
    if (wr_en)
    begin
      unique case (paddr)
        fcd_pkg::REG_BAND:
        begin
          wlim = clamp(pwdata, fcd_pkg::BAND_MAX);
          nxt_band = wlim[6:0];
        end
        fcd_pkg::REG_FREQ_LVL:
        begin
          wlim = clamp(pwdata, fcd_pkg::FREQ_MAX);
          nxt_freq_lvl = wlim[fcd_pkg::FREQ_W-1:0];
        end
        fcd_pkg::REG_REV_LVL:
        begin
          wlim = clamp(pwdata, fcd_pkg::FREQ_MAX);
          if (pwdata == {18'h00000, fcd_pkg::REV_SENTINEL})
            nxt_rev_lvl = fcd_pkg::REV_SENTINEL;
          else
            nxt_rev_lvl = wlim[13:0];
        end
        fcd_pkg::REG_OC_LVL:
        begin
          wlim = clamp(pwdata, fcd_pkg::CUR_MAX);
          nxt_oc_lvl = wlim[fcd_pkg::CUR_W-1:0];
        end
        fcd_pkg::REG_OC_DLY:
        begin
          wlim = clamp(pwdata, fcd_pkg::TIME_MAX);
          nxt_oc_dly = wlim[6:0];
        end
        fcd_pkg::REG_ZC_LVL:
        begin
          wlim = clamp(pwdata, fcd_pkg::CUR_MAX);
          nxt_zc_lvl = wlim[fcd_pkg::CUR_W-1:0];
        end
        fcd_pkg::REG_ZC_TIME:
        begin
          wlim = clamp(pwdata, fcd_pkg::TIME_MAX);
          nxt_zc_time = wlim[6:0];
        end
        fcd_pkg::REG_TERM:
        begin
          for (int i = 0; i < 3; i++)
          begin
            sel_w = pwdata[i*fcd_pkg::SEL_W +: fcd_pkg::SEL_W];
            wlim = clamp({24'h000000, sel_w}, fcd_pkg::SEL_MAX);
            nxt_term_sel[i*fcd_pkg::SEL_W +: fcd_pkg::SEL_W] = wlim[7:0];
          end
        end
        default:
        begin
          wlim = 16'h0000;
        end
      endcase
    end
  end

  // Read data is latched in the setup cycle, valid through the access cycle
  always_comb
  begin
    nxt_prdata = prdata_ff;
    if (psel && !penable && !pwrite)
    begin
      nxt_prdata = 32'h00000000;
      unique case (paddr)
        fcd_pkg::REG_BAND: nxt_prdata[6:0] = band_ff;
        fcd_pkg::REG_FREQ_LVL: nxt_prdata[fcd_pkg::FREQ_W-1:0] = freq_lvl_ff;
        fcd_pkg::REG_REV_LVL: nxt_prdata[13:0] = rev_lvl_ff;
        fcd_pkg::REG_OC_LVL: nxt_prdata[fcd_pkg::CUR_W-1:0] = oc_lvl_ff;
        fcd_pkg::REG_OC_DLY: nxt_prdata[6:0] = oc_dly_ff;
        fcd_pkg::REG_ZC_LVL: nxt_prdata[fcd_pkg::CUR_W-1:0] = zc_lvl_ff;
        fcd_pkg::REG_ZC_TIME: nxt_prdata[6:0] = zc_time_ff;
        fcd_pkg::REG_TERM: nxt_prdata[3*fcd_pkg::SEL_W-1:0] = term_sel_ff;
        fcd_pkg::REG_STATUS: nxt_prdata = status_word;
        default: nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      band_ff <= fcd_pkg::BAND_RST;
      freq_lvl_ff <= fcd_pkg::FREQ_LVL_RST;
      rev_lvl_ff <= fcd_pkg::REV_LVL_RST;
      oc_lvl_ff <= fcd_pkg::OC_LVL_RST;
      oc_dly_ff <= fcd_pkg::OC_DLY_RST;
      zc_lvl_ff <= fcd_pkg::ZC_LVL_RST;
      zc_time_ff <= fcd_pkg::ZC_TIME_RST;
      term_sel_ff <= {fcd_pkg::TERM2_RST, fcd_pkg::TERM1_RST, fcd_pkg::TERM0_RST};
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      band_ff <= nxt_band;
      freq_lvl_ff <= nxt_freq_lvl;
      rev_lvl_ff <= nxt_rev_lvl;
      oc_lvl_ff <= nxt_oc_lvl;
      oc_dly_ff <= nxt_oc_dly;
      zc_lvl_ff <= nxt_zc_lvl;
      zc_time_ff <= nxt_zc_time;
      term_sel_ff <= nxt_term_sel;
      prdata_ff <= nxt_prdata;
    end
  end

  // ****************************************
  // Millisecond timebase
  // ****************************************
  // 1 ms resolution keeps timer latency far under the 0.1 s response
  logic [fcd_pkg::TICK_W-1:0] pre_ff;
  logic [fcd_pkg::TICK_W-1:0] nxt_pre;
  logic tick;

  assign tick = (pre_ff == fcd_pkg::TICK_W'(TICK_CYCLES - 1));

  always_comb
  begin
    nxt_pre = tick ? '0 : pre_ff + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_ff <= '0;
    else
      pre_ff <= nxt_pre;
  end

  // ****************************************
  // Frequency detection
  // ****************************************
  logic sp_ff;
  logic nxt_sp;
  logic fq_ff;
  logic nxt_fq;
  logic [fcd_pkg::FREQ_W-1:0] level_sel;
  logic [fcd_pkg::FREQ_W-1:0] fdiff;
  logic [19:0] diff_scaled;
  logic [19:0] band_scaled;

  // Only the uncompensated frequency is compared
  always_comb
  begin
    if (dir_reverse && (rev_lvl_ff != fcd_pkg::REV_SENTINEL))
      level_sel = rev_lvl_ff[fcd_pkg::FREQ_W-1:0];
    else
      level_sel = freq_lvl_ff;
    fdiff = (out_freq_pre_slip > set_freq) ? out_freq_pre_slip - set_freq
                                           : set_freq - out_freq_pre_slip;
    diff_scaled = {8'h00, fdiff} * fcd_pkg::PCT_SCALE;
    band_scaled = {13'h0000, band_ff} * {8'h00, set_freq};
    nxt_sp = !dc_brake_active && (diff_scaled <= band_scaled);
    nxt_fq = !dc_brake_active && (out_freq_pre_slip >= level_sel);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_ff <= 1'b0;
      fq_ff <= 1'b0;
    end
    else
    begin
      sp_ff <= nxt_sp;
      fq_ff <= nxt_fq;
    end
  end

  // ****************************************
  // Current detection
  // ****************************************
  logic cur_active;
  logic oc_qual;
  logic zc_qual;
  logic oc_done;
  logic zc_done;
  logic [fcd_pkg::DLY_W-1:0] oc_limit;
  logic [fcd_pkg::DLY_W-1:0] zc_limit;
  logic [fcd_pkg::HOLD_W-1:0] hold_ff;
  logic [fcd_pkg::HOLD_W-1:0] nxt_hold;
  logic oc_ff;
  logic nxt_oc;
  logic zc_ff;
  logic nxt_zc;

  assign cur_active = drive_running || autotune_active;
  assign oc_qual = cur_active && (out_current > oc_lvl_ff);
  assign zc_qual = cur_active && (zc_lvl_ff != '0) && (out_current < zc_lvl_ff);
  assign oc_limit = {7'h00, oc_dly_ff} * fcd_pkg::OC_DLY_MS_PER_LSB;
  assign zc_limit = {7'h00, zc_time_ff} * fcd_pkg::ZC_TIME_MS_PER_LSB;

  fcd_delay_timer u_oc_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .qualify(oc_qual),
    .limit(oc_limit),
    .done(oc_done)
  );

  fcd_delay_timer u_zc_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .qualify(zc_qual),
    .limit(zc_limit),
    .done(zc_done)
  );

  // Hold reloads while detection is true, so it runs out 100 ms after the end
  always_comb
  begin
    nxt_hold = hold_ff;
    if (oc_done)
      nxt_hold = fcd_pkg::HOLD_W'(fcd_pkg::OC_HOLD_MS);
    else if (tick && (hold_ff != '0))
      nxt_hold = hold_ff - 1'b1;
    nxt_oc = oc_done || (hold_ff != '0);
    nxt_zc = zc_done;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_ff <= '0;
      oc_ff <= 1'b0;
      zc_ff <= 1'b0;
    end
    else
    begin
      hold_ff <= nxt_hold;
      oc_ff <= nxt_oc;
      zc_ff <= nxt_zc;
    end
  end

  // ****************************************
  // Terminals and status
  // ****************************************
  fcd_term_sel u_term_sel
  (
    .pclk(pclk),
    .presetn(presetn),
    .sp_flag(sp_ff),
    .fq_flag(fq_ff),
    .oc_flag(oc_ff),
    .zc_flag(zc_ff),
    .sel_codes(term_sel_ff),
    .term_out(term_out),
    .fq_term_out(fq_term_out)
  );

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[fcd_pkg::ST_SP] = sp_ff;
    status_word[fcd_pkg::ST_FQ] = fq_ff;
    status_word[fcd_pkg::ST_OC] = oc_ff;
    status_word[fcd_pkg::ST_ZC] = zc_ff;
    status_word[fcd_pkg::ST_TERM_LSB +: 3] = term_out;
    status_word[fcd_pkg::ST_FQ_TERM] = fq_term_out;
  end

  assign at_speed_flag = sp_ff;
  assign freq_level_flag = fq_ff;
  assign overcurrent_level_flag = oc_ff;
  assign zero_current_flag = zc_ff;

endmodule

// >>> tb/fcd_chk_sva.sv
// Port checker for fcd_top.
// Bound from tb; sees only the top ports, one clock domain.
`timescale 1ns/100ps
module fcd_chk
#(
  parameter int TICK_CYCLES = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [fcd_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [fcd_pkg::FREQ_W-1:0] out_freq_pre_slip,
  input wire logic dir_reverse,
  input wire logic drive_running,
  input wire logic dc_brake_active,
  input wire logic autotune_active,
  input wire logic at_speed_flag,
  input wire logic freq_level_flag,
  input wire logic overcurrent_level_flag,
  input wire logic zero_current_flag,
  input wire logic fq_term_out
);
  logic [11:0] lvl_ff;
  logic [11:0] nxt_lvl;
  logic [19:0] hi_ff;
  logic [19:0] nxt_hi;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the detect level, and length of each over-current pulse
  always_comb
  begin
    nxt_lvl = lvl_ff;
    if (psel && penable && pwrite && paddr == fcd_pkg::REG_FREQ_LVL)
      nxt_lvl = (pwdata > {16'h0000, fcd_pkg::FREQ_MAX}) ? 12'hFA0 : pwdata[11:0];
    nxt_hi = overcurrent_level_flag ? hi_ff + 20'h00001 : 20'h00000;
  end
  // Registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_ff <= fcd_pkg::FREQ_LVL_RST;
      hi_ff <= 20'h00000;
    end
    else
    begin
      lvl_ff <= nxt_lvl;
      hi_ff <= nxt_hi;
    end
  end
  // ****
  // Assertions
  // ****
  brake_off_a: assert property (dc_brake_active |=> !at_speed_flag && !freq_level_flag)
    else $error("frequency flag set during braking");
  fq_fwd_a: assert property (!dc_brake_active && !dir_reverse |=>
    freq_level_flag == ($past(out_freq_pre_slip) >= $past(lvl_ff)))
    else $error("frequency level flag wrong");
  fq_term_a: assert property (fq_term_out == $past(freq_level_flag))
    else $error("dedicated terminal does not follow flag");
  oc_hold_a: assert property ($fell(overcurrent_level_flag) |-> hi_ff >= 99 * TICK_CYCLES)
    else $error("over-current pulse too short");
  zc_idle_a: assert property ((!drive_running && !autotune_active)[*3] |-> !zero_current_flag)
    else $error("zero-current flag while stopped");
  rdy_now_a: assert property (psel && penable |-> pready)
    else $error("access not completed");
  err_map_a: assert property (psel && penable && (paddr > fcd_pkg::REG_STATUS ||
    pwrite && paddr == fcd_pkg::REG_STATUS) |-> pslverr)
    else $error("bad access not refused");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  cover property ($rose(overcurrent_level_flag));
  cover property ($rose(zero_current_flag));
  cover property (psel && penable && pslverr);
endmodule

// >>> tb/fcd_brake_model.sv
// Brake equipment on the zero-current terminal.
// Assumes coil level from pclk logic; one cycle contactor lag.
`timescale 1ns/100ps
module fcd_brake_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic coil,
  output logic brake_closed_ff
);
  logic nxt_closed;
  // Energised coil closes the brake
  always_comb
  begin
    nxt_closed = coil;
  end
  // Open brake after reset, the safe idle for a moving load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brake_closed_ff <= 1'b0;
    else
      brake_closed_ff <= nxt_closed;
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for fcd_top with the brake model.
// Assumes a short timebase: one ms is 10 clock cycles.
`timescale 1ns/100ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, sp, fq, oc, zc, fut, brk;
  logic [11:0] fo = 12'h000;
  logic [11:0] fs = 12'h000;
  logic [10:0] cur = 11'h000;
  logic [3:0] m = 4'h0;
  logic [2:0] tout;
  int miscompares = 0;
  int n_compared = 0;
  fcd_top #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_freq_pre_slip(fo), .set_freq(fs),
    .dir_reverse(m[1]), .out_current(cur), .drive_running(m[3]), .dc_brake_active(m[0]),
    .autotune_active(m[2]), .at_speed_flag(sp), .freq_level_flag(fq),
    .overcurrent_level_flag(oc), .zero_current_flag(zc), .term_out(tout),
    .fq_term_out(fut));
  fcd_brake_model brake (.pclk(pclk), .presetn(presetn), .coil(tout[2]),
    .brake_closed_ff(brk));
  // Free-running 100 MHz clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; waits on pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Drive inputs; mode is run, tune, reverse, brake
  task automatic put(input logic [11:0] f, s, input logic [10:0] c, input logic [3:0] md);
    @(posedge pclk);
    fo <= f;
    fs <= s;
    cur <= c;
    m <= md;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    logic [31:0] v [8] = '{32'hA, 32'h3C, 32'h270F, 32'h5DC, 32'h0, 32'h32, 32'h32, 32'hD0C01};
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rd, v[i]);
    end
    apb(1'b1, 8'h00, 32'h96);
    apb(1'b0, 8'h00, 32'h0);
    chk("band limit", rd, 32'h64);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("status", rd, 32'h11);
    apb(1'b1, 8'h20, 32'hF);
    chk("status write", {31'h0, er}, 32'h1);
  endtask
  // Band edges at 0 % and 100 %, then braking
  task automatic t_sp;
    logic [11:0] f [6] = '{12'd500, 12'd501, 12'd1000, 12'd0, 12'd1001, 12'd500};
    logic e [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    apb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 2)
        apb(1'b1, 8'h00, 32'h64);
      put(f[i], 12'd500, 11'd0, (i == 5) ? 4'h1 : 4'h0);
      cyc(4);
      chk("at speed", {sp, tout[0], fq}, {e[i], e[i], i != 5 && f[i] > 59});
    end
    apb(1'b1, 8'h00, 32'hA);
  endtask
  // Forward level, sentinel, own reverse level
  task automatic t_fq;
    logic [11:0] f [7] = '{12'd60, 12'd59, 12'd60, 12'd59, 12'd99, 12'd100, 12'd99};
    logic [3:0] md [7] = '{4'h0, 4'h0, 4'h2, 4'h2, 4'h2, 4'h2, 4'h0};
    logic e [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 7; i++)
    begin
      if (i == 4)
        apb(1'b1, 8'h08, 32'h64);
      put(f[i], 12'd0, 11'd0, md[i]);
      cyc(4);
      chk("freq level", {fq, fut}, {e[i], e[i]});
    end
    apb(1'b1, 8'h08, 32'h270F);
  endtask
  // Each flag code and unused code 7 on terminal 0, both logic senses
  task automatic t_term;
    logic [7:0] c [10] = '{8'd1, 8'd101, 8'd4, 8'd104, 8'd12, 8'd112, 8'd13, 8'd113, 8'd7, 8'd107};
    logic act;
    put(12'd500, 12'd500, 11'd0, 4'h0);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, 8'h1C, {24'h000D0C, c[i]});
      cyc(3);
      act = (c[i] % 100 == 1) || (c[i] % 100 == 4);
      chk("terminal", {31'h0, tout[0]}, {31'h0, act ^ (c[i] >= 100)});
    end
    apb(1'b1, 8'h1C, 32'h000D0C01);
  endtask
  task automatic t_oc;
    put(12'd0, 12'd0, 11'd1500, 4'h8);
    cyc(20);
    chk("oc at level", {31'h0, oc}, 32'h0);
    put(12'd0, 12'd0, 11'd1501, 4'h8);
    cyc(4);
    chk("oc no delay", {oc, tout[1]}, 2'b11);
    put(12'd0, 12'd0, 11'd1000, 4'h8);
    cyc(900);
    chk("oc hold", {31'h0, oc}, 32'h1);
    cyc(130);
    chk("oc release", {31'h0, oc}, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    put(12'd0, 12'd0, 11'd1501, 4'h4);
    cyc(500);
    put(12'd0, 12'd0, 11'd1000, 4'h4);
    put(12'd0, 12'd0, 11'd1501, 4'h4);
    cyc(800);
    chk("oc restart", {31'h0, oc}, 32'h0);
    cyc(250);
    chk("oc tuning", {31'h0, oc}, 32'h1);
    put(12'd0, 12'd0, 11'd0, 4'h0);
    apb(1'b1, 8'h10, 32'h0);
    cyc(1100);
  endtask
  // Short zero-current time, as the configuration should keep it
  task automatic t_zc;
    apb(1'b1, 8'h18, 32'h1);
    put(12'd0, 12'd0, 11'd49, 4'h8);
    cyc(60);
    chk("zc early", {31'h0, zc}, 32'h0);
    cyc(80);
    chk("zc set", {zc, tout[2]}, 2'b11);
    cyc(2);
    chk("brake", {31'h0, brk}, 32'h1);
    put(12'd0, 12'd0, 11'd50, 4'h8);
    cyc(4);
    chk("zc at level", {31'h0, zc}, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    put(12'd0, 12'd0, 11'd0, 4'h8);
    cyc(200);
    chk("zc disabled", {31'h0, zc}, 32'h0);
    put(12'd0, 12'd0, 11'd0, 4'h0);
    apb(1'b1, 8'h14, 32'h32);
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sp();
    t_fq();
    t_term();
    t_oc();
    t_zc();
    tally_and_finish();
  end
endmodule
bind fcd_top fcd_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
